/* logic/uwf_defines.svh */
`ifndef UWF_DEFINES_SVH
`define UWF_DEFINES_SVH

// ==========================================================================
// Queue geometry
`define UWF_CMD_DEPTH        1024
`define UWF_CMD_WIDTH        36
`define UWF_CMD_ADDR_BITS    32
`define UWF_CMD_CODE_BITS    4
`define UWF_DATA_DEPTH       512
`define UWF_SLICE_WIDTH      72
`define UWF_SLICE_DATA_BITS  64
`define UWF_SLICE_CHECK_BITS 8
`define UWF_SLICE_HALF_DATA  32
`define UWF_SLICE_HALF_MASK  4
`define UWF_NARROW_MAX_DQ    32
`define UWF_WIDE_DQ          72
`define UWF_WIDE_SLICES      3
`define UWF_BYTE_BITS        8
`define UWF_AFULL_SLACK      12

// ==========================================================================
// Command codes
`define UWF_CODE_WRITE       3'h0
`define UWF_CODE_READ        3'h1

// ==========================================================================
// Register offsets (byte addresses)
`define UWF_CTRL_OFS         32'h0000_0000
`define UWF_STATUS_OFS       32'h0000_0004
`define UWF_LEVEL_OFS        32'h0000_0008
`define UWF_CONFIG_OFS       32'h0000_000c

// ==========================================================================
// Field positions and reset values
`define UWF_CTRL_DRAIN_BIT   0
`define UWF_CTRL_RESET       1'h1
`define UWF_ST_INIT_BIT      0
`define UWF_ST_CEMPTY_BIT    1
`define UWF_ST_CFULL_BIT     2
`define UWF_ST_DEMPTY_BIT    3
`define UWF_ST_DFULL_BIT     4
`define UWF_ST_BUSY_BIT      5
`define UWF_LVL_CMD_POS      0
`define UWF_LVL_DATA_POS     16
`define UWF_CFG_DQ_POS       0
`define UWF_CFG_SLICES_POS   8
`define UWF_CFG_ECC_BIT      12
`define UWF_CFG_MASK_BIT     13

`endif

/* logic/uwf_pkg.sv */
`default_nettype none
package uwf_pkg;
	// Drain engine states
	typedef enum logic [1:0] {UWF_IDLE, UWF_CMD, UWF_DATA} uwf_drain_state_type;
	// Three-bit request command code
	typedef logic [2:0] uwf_code_type;
endpackage
`default_nettype wire

/* logic/uwf_fifo_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Queue port bundle: store side is the queue, user side feeds and drains it
interface uwf_fifo_if #(
	parameter int WIDTH = 72,
	parameter int DEPTH = 512
);
	localparam int CW = $clog2(DEPTH) + 1;
	logic             push;
	logic [WIDTH-1:0] push_data;
	logic             pop;
	logic [WIDTH-1:0] pop_data;
	logic             empty;
	logic             afull;
	logic [CW-1:0]    count;
	modport store (input push, push_data, pop, output pop_data, empty, afull, count);
	modport user  (output push, push_data, pop, input pop_data, empty, afull, count);
endinterface
`default_nettype wire

/* logic/uwf_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
`include "uwf_defines.svh"
// ==========================================================================
// Show-ahead queue with almost-full flag and optional check-bit generation
module uwf_fifo #(
	parameter int WIDTH     = `UWF_SLICE_WIDTH,
	parameter int DEPTH     = `UWF_DATA_DEPTH,
	parameter int SLACK     = `UWF_AFULL_SLACK,
	parameter bit GEN_CHECK = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	uwf_fifo_if.store q
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam int DB = `UWF_SLICE_DATA_BITS;
	localparam int KB = `UWF_SLICE_CHECK_BITS;
	localparam logic [CW-1:0] FULL_AT  = CW'(DEPTH);
	localparam logic [CW-1:0] AFULL_AT = CW'(DEPTH - SLACK);

	// ======================================================================
	// Elaboration checks
	if ((1 << AW) != DEPTH || SLACK < 1 || SLACK >= DEPTH)
		$error("uwf_fifo: depth must be a power of two above the slack");
	if (GEN_CHECK && WIDTH != DB + KB)
		$error("uwf_fifo: check bits need a 64+8 entry");

	// ======================================================================
	// Check bits: seven position parities plus one overall parity
	function automatic logic [KB-1:0] check_bits(input logic [DB-1:0] d);
		logic [KB-1:0] c;
		c = '0;
		for (int j = 0; j < DB; j++)
		begin
			for (int i = 0; i < KB - 1; i++)
				if (j[i])
					c[i] = c[i] ^ d[j];
			c[KB-1] = c[KB-1] ^ d[j];
		end
		return c;
	endfunction

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	logic [CW-1:0]    next_count;
	logic             afull;
	logic [WIDTH-1:0] stored;

	// ======================================================================
	// Accept and release qualifiers; a push into a full queue is dropped
	wire do_push = q.push & (count != FULL_AT);
	wire do_pop  = q.pop & (count != '0);
	// Narrow queues never elaborate the 64-bit data select
	if (GEN_CHECK)
	begin : g_check
		assign stored = {check_bits(q.push_data[DB-1:0]), q.push_data[DB-1:0]};
	end
	else
	begin : g_plain
		assign stored = q.push_data;
	end
	always_comb
	begin
		next_count = count;
		if (do_push & ~do_pop)
			next_count = count + CW'(1);
		else if (do_pop & ~do_push)
			next_count = count - CW'(1);
	end

	// Storage array carries no reset; the pointers, level and flag do
	always_ff @(posedge clk)
	begin
		if (ce & do_push)
			mem[wr_ptr] <= stored;
	end

	// Pointers and level; the flag is registered from the next level
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
			afull  <= 1'b0;
		end
		else if (ce)
		begin
			wr_ptr <= do_push ? wr_ptr + AW'(1) : wr_ptr;
			rd_ptr <= do_pop ? rd_ptr + AW'(1) : rd_ptr;
			count  <= next_count;
			afull  <= (next_count >= AFULL_AT);
		end
	end

	assign q.pop_data = mem[rd_ptr];
	assign q.empty    = (count == '0);
	assign q.afull    = afull;
	assign q.count    = count;
endmodule // uwf_fifo
`default_nettype wire

/* logic/uwf_top.sv */
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "uwf_defines.svh"
module uwf_top #(
	parameter int DQ_WIDTH       = `UWF_WIDE_DQ,
	parameter int ADDR_WIDTH     = 31,
	parameter int COL_WIDTH      = 10,
	parameter int ROW_WIDTH      = 14,
	parameter int BANK_WIDTH     = 3,
	parameter int BURST_LEN      = 4,
	parameter bit ECC_ENABLE     = 1'b0,
	parameter bit MASK_SUPPORTED = 1'b1,
	parameter bit MASK_ENABLE    = 1'b1,
	localparam int DM_WIDTH      = DQ_WIDTH / `UWF_BYTE_BITS,
	localparam int SLICES        = (DQ_WIDTH > `UWF_NARROW_MAX_DQ) ? `UWF_WIDE_SLICES : 1
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   ce,
	// User command queue
	input  wire uwf_pkg::uwf_code_type  request_command_code,
	input  wire logic [ADDR_WIDTH-1:0]  request_address,
	input  wire logic                   request_queue_push,
	output logic                        request_queue_full,
	// User write data queue
	input  wire logic [2*DQ_WIDTH-1:0]  write_data,
	input  wire logic [2*DM_WIDTH-1:0]  write_mask,
	input  wire logic                   write_queue_push,
	output logic                        write_queue_full,
	// Calibration status
	input  wire logic                   init_done,
	// Memory-side command stream
	output logic                        mem_cmd_valid,
	input  wire logic                   mem_cmd_ready,
	output uwf_pkg::uwf_code_type       mem_cmd_code,
	output logic [BANK_WIDTH-1:0]       mem_bank,
	output logic [ROW_WIDTH-1:0]        mem_row,
	output logic [COL_WIDTH-1:0]        mem_col,
	// Memory-side write data stream
	output logic                        mem_wr_valid,
	input  wire logic                   mem_wr_ready,
	output logic [2*DQ_WIDTH-1:0]       mem_wr_data,
	output logic [2*DM_WIDTH-1:0]       mem_wr_mask,
	output logic [8*SLICES-1:0]         mem_wr_check,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata
);
	import uwf_pkg::*;

	localparam int SW    = `UWF_SLICE_WIDTH;
	localparam int DB    = `UWF_SLICE_DATA_BITS;
	localparam int HD    = `UWF_SLICE_HALF_DATA;
	localparam int HM    = `UWF_SLICE_HALF_MASK;
	localparam int KB    = `UWF_SLICE_CHECK_BITS;
	localparam int WORDS = BURST_LEN / 2;
	localparam bit KEEP_MASK = MASK_SUPPORTED & MASK_ENABLE & ~ECC_ENABLE;

	// ======================================================================
	// Elaboration checks
	if (DQ_WIDTH % `UWF_BYTE_BITS != 0 || DQ_WIDTH < `UWF_BYTE_BITS
		|| (DQ_WIDTH > `UWF_NARROW_MAX_DQ && DQ_WIDTH != `UWF_WIDE_DQ))
		$error("uwf_top: memory width must be 8 to 32 in bytes, or 72");
	if (COL_WIDTH + ROW_WIDTH + BANK_WIDTH > ADDR_WIDTH || ADDR_WIDTH > `UWF_CMD_ADDR_BITS)
		$error("uwf_top: address fields do not fit the request address");
	if (BURST_LEN != 4 && BURST_LEN != 8)
		$error("uwf_top: burst length must be 4 or 8");

	// ======================================================================
	// Command queue: 32-bit address section, 4-bit command section
	uwf_fifo_if #(.WIDTH(`UWF_CMD_WIDTH), .DEPTH(`UWF_CMD_DEPTH)) cq ();
	uwf_fifo #(
		.WIDTH     (`UWF_CMD_WIDTH),
		.DEPTH     (`UWF_CMD_DEPTH),
		.SLACK     (`UWF_AFULL_SLACK),
		.GEN_CHECK (1'b0)
	) u_cmd_fifo (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.q     (cq.store)
	);

	logic [`UWF_CMD_ADDR_BITS-1:0] cmd_addr_ext;
	always_comb
	begin
		cmd_addr_ext = '0;
		cmd_addr_ext[ADDR_WIDTH-1:0] = request_address;
	end
	// Both reads and writes share this queue; only the code separates them
	assign cq.push      = request_queue_push;
	assign cq.push_data = {1'b0, request_command_code, cmd_addr_ext};
	wire uwf_code_type head_code = cq.pop_data[`UWF_CMD_ADDR_BITS +: 3];
	wire [`UWF_CMD_ADDR_BITS-1:0] head_addr = cq.pop_data[`UWF_CMD_ADDR_BITS-1:0];
	wire head_is_write = (head_code == `UWF_CODE_WRITE);

	// ======================================================================
	// Lane routing of the user word into slice entries
	localparam int PW = SLICES * HD;
	localparam int PM = SLICES * HM;
	// Narrow packing widths, clipped so the unused wide case stays in range
	localparam int NPD = (2*DQ_WIDTH < DB) ? 2*DQ_WIDTH : DB;
	localparam int NPM = (2*DM_WIDTH < KB) ? 2*DM_WIDTH : KB;
	logic [PW-1:0]    rise_pad;
	logic [PW-1:0]    fall_pad;
	logic [PM-1:0]    rmask_pad;
	logic [PM-1:0]    fmask_pad;
	logic [2*DM_WIDTH-1:0] kept_mask;
	logic [SW-1:0]    push_word [SLICES];
	logic [SW-1:0]    pop_word  [SLICES];
	logic [SLICES-1:0] slice_empty;
	logic [SLICES-1:0] slice_afull;
	logic [9:0]       data_count;

	// No mask path exists unless the part and configuration allow it
	assign kept_mask = KEEP_MASK ? write_mask : '0;

	always_comb
	begin
		rise_pad  = '0;
		fall_pad  = '0;
		rmask_pad = '0;
		fmask_pad = '0;
		rise_pad[DQ_WIDTH-1:0]  = write_data[DQ_WIDTH-1:0];
		fall_pad[DQ_WIDTH-1:0]  = write_data[2*DQ_WIDTH-1:DQ_WIDTH];
		rmask_pad[DM_WIDTH-1:0] = kept_mask[DM_WIDTH-1:0];
		fmask_pad[DM_WIDTH-1:0] = kept_mask[2*DM_WIDTH-1:DM_WIDTH];
		for (int s = 0; s < SLICES; s++)
		begin
			push_word[s] = '0;
			if (SLICES == 1)
			begin
				// Narrow widths pack low and pad the rest with zeros
				push_word[s][NPD-1:0] = write_data[NPD-1:0];
				push_word[s][DB +: NPM] = kept_mask[NPM-1:0];
			end
			else
			begin
				push_word[s][0 +: HD]       = rise_pad[s*HD +: HD];
				push_word[s][HD +: HD]      = fall_pad[s*HD +: HD];
				push_word[s][DB +: HM]      = rmask_pad[s*HM +: HM];
				push_word[s][DB + HM +: HM] = fmask_pad[s*HM +: HM];
			end
		end
	end

	// ======================================================================
	// Data queue slices, one per 32-bit lane pair
	logic data_pop;
	for (genvar s = 0; s < SLICES; s++)
	begin : g_slice
		uwf_fifo_if #(.WIDTH(SW), .DEPTH(`UWF_DATA_DEPTH)) dq ();
		uwf_fifo #(
			.WIDTH     (SW),
			.DEPTH     (`UWF_DATA_DEPTH),
			.SLACK     (`UWF_AFULL_SLACK),
			.GEN_CHECK (ECC_ENABLE)
		) u_data_fifo (
			.clk   (clk),
			.rst_n (rst_n),
			.ce    (ce),
			.q     (dq.store)
		);
		assign dq.push      = write_queue_push;
		assign dq.push_data = push_word[s];
		assign dq.pop       = data_pop;
		assign pop_word[s]    = dq.pop_data;
		assign slice_empty[s] = dq.empty;
		assign slice_afull[s] = dq.afull;
		if (s == 0)
		begin : g_level
			assign data_count = dq.count;
		end
	end

	// ======================================================================
	// Reassembly of a popped entry into the memory-side word
	logic [PW-1:0]         out_rise;
	logic [PW-1:0]         out_fall;
	logic [PM-1:0]         out_rmask;
	logic [PM-1:0]         out_fmask;
	logic [2*DQ_WIDTH-1:0] out_data;
	logic [2*DM_WIDTH-1:0] out_mask;
	logic [8*SLICES-1:0]   out_check;
	always_comb
	begin
		for (int s = 0; s < SLICES; s++)
		begin
			out_rise[s*HD +: HD]  = pop_word[s][0 +: HD];
			out_fall[s*HD +: HD]  = pop_word[s][HD +: HD];
			out_rmask[s*HM +: HM] = pop_word[s][DB +: HM];
			out_fmask[s*HM +: HM] = pop_word[s][DB + HM +: HM];
			out_check[s*KB +: KB] = ECC_ENABLE ? pop_word[s][DB +: KB] : '0;
		end
		if (SLICES == 1)
		begin
			out_data = '0;
			out_mask = '0;
			out_data[NPD-1:0] = pop_word[0][NPD-1:0];
			out_mask[NPM-1:0] = pop_word[0][DB +: NPM];
		end
		else
		begin
			out_data = {out_fall[DQ_WIDTH-1:0], out_rise[DQ_WIDTH-1:0]};
			out_mask = {out_fmask[DM_WIDTH-1:0], out_rmask[DM_WIDTH-1:0]};
		end
		if (!KEEP_MASK)
			out_mask = '0;
	end

	// ======================================================================
	// Drain engine
	uwf_drain_state_type state;
	uwf_drain_state_type next_state;
	logic [3:0]          words_left;
	logic                drain_en;
	logic                head_was_write;

	// Start only once calibration is done and a command is waiting
	wire go        = drain_en & init_done & ~cq.empty;
	wire cmd_pop   = (state == UWF_IDLE) & go;
	wire wr_free   = ~mem_wr_valid | mem_wr_ready;
	// All slices move in lockstep, so any empty slice stalls the word
	wire data_take = (state == UWF_DATA) & (words_left != '0)
		& ~(|slice_empty) & wr_free;
	assign cq.pop   = cmd_pop;
	assign data_pop = data_take;

	always_comb
	begin
		next_state = state;
		unique case (state)
			UWF_IDLE:
				if (go)
					next_state = UWF_CMD;
			UWF_CMD:
				if (mem_cmd_ready)
					next_state = head_was_write ? UWF_DATA : UWF_IDLE;
			UWF_DATA:
				if (words_left == '0 && wr_free)
					next_state = UWF_IDLE;
			default:
				next_state = UWF_IDLE;
		endcase
	end

	// State and burst countdown
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state      <= UWF_IDLE;
			words_left <= '0;
		end
		else if (ce)
		begin
			state <= next_state;
			if (state == UWF_CMD && mem_cmd_ready)
				words_left <= 4'(WORDS);
			else if (data_take)
				words_left <= words_left - 4'h1;
		end
	end

	// Command outputs, split linearly from the stored address
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mem_cmd_valid  <= 1'b0;
			mem_cmd_code   <= `UWF_CODE_WRITE;
			mem_bank       <= '0;
			mem_row        <= '0;
			mem_col        <= '0;
			head_was_write <= 1'b0;
		end
		else if (ce)
		begin
			if (cmd_pop)
			begin
				mem_cmd_valid  <= 1'b1;
				mem_cmd_code   <= head_code;
				head_was_write <= head_is_write;
				mem_col  <= head_addr[COL_WIDTH-1:0];
				mem_row  <= head_addr[COL_WIDTH +: ROW_WIDTH];
				mem_bank <= head_addr[COL_WIDTH + ROW_WIDTH +: BANK_WIDTH];
			end
			else if (mem_cmd_ready)
				mem_cmd_valid <= 1'b0;
		end
	end

	// Write data outputs; each popped entry stands until accepted
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mem_wr_valid <= 1'b0;
			mem_wr_data  <= '0;
			mem_wr_mask  <= '0;
			mem_wr_check <= '0;
		end
		else if (ce)
		begin
			if (data_take)
			begin
				mem_wr_valid <= 1'b1;
				mem_wr_data  <= out_data;
				mem_wr_mask  <= out_mask;
				mem_wr_check <= out_check;
			end
			else if (mem_wr_ready)
				mem_wr_valid <= 1'b0;
		end
	end

	// Full flags straight from the queue flops
	assign request_queue_full = cq.afull;
	// Slices share every push and pop, so slice 0's flop speaks for all
	assign write_queue_full   = slice_afull[0];

	// ======================================================================
	// AHB-Lite slave: zero wait states, always OKAY
	logic        ph_write;
	logic [31:0] ph_addr;
	wire ahb_take = hsel & hready & htrans[1];
	wire sel_ctrl = (haddr == `UWF_CTRL_OFS);
	wire sel_stat = (haddr == `UWF_STATUS_OFS);
	wire sel_lvl  = (haddr == `UWF_LEVEL_OFS);
	wire sel_cfg  = (haddr == `UWF_CONFIG_OFS);
	wire wr_ctrl  = ph_write & (ph_addr == `UWF_CTRL_OFS);

	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = '0; // Unmapped reads return zero
		if (sel_ctrl)
			rd_mux[`UWF_CTRL_DRAIN_BIT] = drain_en;
		if (sel_stat)
		begin
			rd_mux[`UWF_ST_INIT_BIT]   = init_done;
			rd_mux[`UWF_ST_CEMPTY_BIT] = cq.empty;
			rd_mux[`UWF_ST_CFULL_BIT]  = request_queue_full;
			rd_mux[`UWF_ST_DEMPTY_BIT] = |slice_empty;
			rd_mux[`UWF_ST_DFULL_BIT]  = |slice_afull;
			rd_mux[`UWF_ST_BUSY_BIT]   = (state != UWF_IDLE);
		end
		if (sel_lvl)
		begin
			rd_mux[`UWF_LVL_CMD_POS +: 11] = cq.count;
			rd_mux[`UWF_LVL_DATA_POS +: 10] = data_count;
		end
		if (sel_cfg)
		begin
			rd_mux[`UWF_CFG_DQ_POS +: 8]     = 8'(DQ_WIDTH);
			rd_mux[`UWF_CFG_SLICES_POS +: 4] = 4'(SLICES);
			rd_mux[`UWF_CFG_ECC_BIT]         = ECC_ENABLE;
			rd_mux[`UWF_CFG_MASK_BIT]        = KEEP_MASK;
		end
	end

	// Address phase capture; read data is fetched here for the data phase
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ph_write  <= 1'b0;
			ph_addr   <= '0;
			hrdata    <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			drain_en  <= `UWF_CTRL_RESET;
		end
		else if (ce)
		begin
			ph_write <= ahb_take & hwrite;
			ph_addr  <= haddr;
			if (ahb_take & ~hwrite)
				hrdata <= rd_mux;
			if (wr_ctrl)
				drain_en <= hwdata[`UWF_CTRL_DRAIN_BIT];
		end
	end
endmodule // uwf_top
`default_nettype wire

/* tb/uwf_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Port-level checks on the queue front end and its drain side
module uwf_checker
	import uwf_pkg::*;
#(
	parameter int DQ_WIDTH   = 72,
	parameter bit ECC_ENABLE = 1'b0
) (
	input wire logic                                clk,
	input wire logic                                rst_n,
	input wire logic                                ce,
	input wire logic                                request_queue_push,
	input wire logic                                request_queue_full,
	input wire logic                                write_queue_push,
	input wire logic                                write_queue_full,
	input wire logic                                init_done,
	input wire logic                                mem_cmd_valid,
	input wire logic                                mem_cmd_ready,
	input wire uwf_pkg::uwf_code_type               mem_cmd_code,
	input wire logic                                mem_wr_valid,
	input wire logic                                mem_wr_ready,
	input wire logic [2*DQ_WIDTH-1:0]               mem_wr_data,
	input wire logic [8*(DQ_WIDTH > 32 ? 3 : 1)-1:0] mem_wr_check
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ==========================================================================
	// Drain handshake steps
	sequence cmd_taken;
		mem_cmd_valid && mem_cmd_ready;
	endsequence
	sequence read_taken;
		cmd_taken ##0 (mem_cmd_code == 3'h1);
	endsequence
	sequence write_taken;
		cmd_taken ##0 (mem_cmd_code == 3'h0);
	endsequence

	// Reset itself is the cause here, so this one is never disabled
	full_reset_a: assert property (disable iff (1'b0)
		(!rst_n && ce) |=> !request_queue_full && !write_queue_full)
		else $error("full flag high after reset");
	drain_gate_a: assert property ($rose(mem_cmd_valid) |-> $past(init_done))
		else $error("command left before calibration done");
	cmd_hold_a: assert property (mem_cmd_valid && !mem_cmd_ready |=>
		mem_cmd_valid && $stable(mem_cmd_code))
		else $error("command dropped or changed while stalled");
	wr_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=>
		mem_wr_valid && $stable(mem_wr_data))
		else $error("write word dropped or changed while stalled");
	read_nodata_a: assert property (read_taken |=> !mem_wr_valid [*3])
		else $error("read command pulled write data");
	write_data_a: assert property (write_taken |-> ##[1:40] mem_wr_valid)
		else $error("write command without data");
	check_zero_a: assert property (mem_wr_valid && !ECC_ENABLE |-> mem_wr_check == '0)
		else $error("check bits without error correction");
	cfull_cause_a: assert property ($rose(request_queue_full) |-> $past(request_queue_push))
		else $error("command full rose without a push");
	wfull_cause_a: assert property ($rose(write_queue_full) |-> $past(write_queue_push))
		else $error("data full rose without a push");
endmodule // uwf_checker

bind uwf_top uwf_checker #(.DQ_WIDTH(DQ_WIDTH), .ECC_ENABLE(ECC_ENABLE)) uwf_checker_i (
	.clk, .rst_n, .ce, .request_queue_push, .request_queue_full, .write_queue_push,
	.write_queue_full, .init_done, .mem_cmd_valid, .mem_cmd_ready, .mem_cmd_code,
	.mem_wr_valid, .mem_wr_ready, .mem_wr_data, .mem_wr_check);
`default_nettype wire

/* tb/uwf_user_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// User backend: issues requests and bulk pushes on the user clock
module uwf_user_model (
	input  wire logic            clk,
	output uwf_pkg::uwf_code_type request_command_code,
	output var logic [30:0]      request_address,
	output var logic             request_queue_push,
	output var logic [143:0]     write_data,
	output var logic [17:0]      write_mask,
	output var logic             write_queue_push
);
	import uwf_pkg::*;
	initial
	begin
		request_command_code = 3'h0;
		request_address = '0;
		request_queue_push = 1'b0;
		write_data = '0;
		write_mask = '0;
		write_queue_push = 1'b0;
	end

	// First word goes in with its command, second word on the very next cycle
	task automatic send(input uwf_code_type c, input logic [30:0] a,
		input logic [143:0] d, input logic [17:0] m);
		@(posedge clk);
		request_queue_push <= 1'b1;
		request_command_code <= c;
		request_address <= a;
		write_queue_push <= (c == 3'h0);
		write_data <= d;
		write_mask <= m;
		@(posedge clk);
		request_queue_push <= 1'b0;
		request_address <= ~a; // Released lines keep moving so stale values never match
		write_data <= ~d;
		write_mask <= ~m;
		@(posedge clk);
		write_queue_push <= 1'b0;
		write_data <= d;
	endtask

	// Back-to-back pushes; reads need no data so the command queue fills alone
	task automatic burst(input bit cmd, input int n);
		request_command_code <= 3'h1;
		repeat (n)
		begin
			@(posedge clk);
			if (cmd)
				request_queue_push <= 1'b1;
			else
				write_queue_push <= 1'b1;
		end
		@(posedge clk);
		request_queue_push <= 1'b0;
		write_queue_push <= 1'b0;
	endtask
endmodule // uwf_user_model
`default_nettype wire

/* tb/uwf_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Bench top: user model in front, alternating memory-side stalls behind
module uwf_tb_top;
	import uwf_pkg::*;
	localparam logic [143:0] D = 144'h0123456789abcdeffedcba98765432100f1e;
	localparam logic [17:0]  M = 18'h2c35a;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, init_done = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic mem_cmd_ready = 1'b0, mem_wr_ready = 1'b0, hreadyout, hresp;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, mem_bank;
	uwf_code_type request_command_code, mem_cmd_code;
	logic [30:0] request_address;
	logic request_queue_push, request_queue_full, write_queue_push, write_queue_full;
	logic mem_cmd_valid, mem_wr_valid;
	logic [143:0] write_data, mem_wr_data;
	logic [17:0] write_mask, mem_wr_mask;
	logic [13:0] mem_row;
	logic [9:0] mem_col;
	logic [23:0] mem_wr_check;
	logic [29:0] cq[$];
	logic [161:0] wq[$];
	int mismatches = 0, checks_done = 0, cycles = 0;

	uwf_user_model uwf_user_model_i (.clk, .request_command_code, .request_address,
		.request_queue_push, .write_data, .write_mask, .write_queue_push);
	uwf_top uwf_top_i (.clk, .rst_n, .ce, .request_command_code, .request_address,
		.request_queue_push, .request_queue_full, .write_data, .write_mask, .write_queue_push,
		.write_queue_full, .init_done, .mem_cmd_valid, .mem_cmd_ready, .mem_cmd_code, .mem_bank,
		.mem_row, .mem_col, .mem_wr_valid, .mem_wr_ready, .mem_wr_data, .mem_wr_mask,
		.mem_wr_check, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata);

	always #50 clk = ~clk;

	// Every second cycle stalls, so both hold paths get exercised
	always @(posedge clk)
	begin
		cycles++;
		mem_cmd_ready <= ~mem_cmd_ready;
		mem_wr_ready <= ~mem_wr_ready;
		if (mem_cmd_valid === 1'b1 && mem_cmd_ready === 1'b1)
			cq.push_back({mem_cmd_code, mem_bank, mem_row, mem_col});
		if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1)
			wq.push_back({mem_wr_mask, mem_wr_data});
		if (cycles == 20000)
		begin
			mismatches++;
			summarize();
		end
	end

	task automatic chk(input logic [161:0] got, input logic [161:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Single word transfer; only hready ends each phase
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// Column low, row above, bank above row
	function automatic logic [29:0] exp_cmd(input logic [2:0] c, input logic [30:0] a);
		return {c, a[26:24], a[23:10], a[9:0]};
	endfunction

	task automatic t_reset;
		#1 chk(request_queue_full, 1'b0);
		chk(write_queue_full, 1'b0);
		chk(hresp, 1'b0);
		ahb(1'b0, 32'h4, 32'h0);
		chk(rd, 32'h0000_000a);
		ahb(1'b0, 32'hc, 32'h0);
		chk(rd, 32'h0000_2348);
		ahb(1'b0, 32'h10, 32'h0);
		chk(rd, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_write;
		uwf_user_model_i.send(3'h0, {4'h0, 3'h5, 14'h1234, 10'h2a5}, D, M);
		repeat (30) @(posedge clk);
		chk(cq.size(), 0);
		init_done <= 1'b1;
		for (int i = 0; i < 60 && wq.size() < 2; i++) @(posedge clk);
		chk(cq.pop_front(), exp_cmd(3'h0, {4'h0, 3'h5, 14'h1234, 10'h2a5}));
		chk(wq.pop_front(), {M, D});
		chk(wq.pop_front(), {~M, ~D});
		$display("test write done");
	endtask

	task automatic t_read;
		uwf_user_model_i.send(3'h1, 31'h0000_4321, D, M);
		for (int i = 0; i < 60 && cq.size() < 1; i++) @(posedge clk);
		repeat (10) @(posedge clk);
		chk(cq.pop_front(), exp_cmd(3'h1, 31'h0000_4321));
		chk(wq.size(), 0);
		$display("test read done");
	endtask

	// Drain off, then fill both queues past their almost-full points
	task automatic t_fill;
		ahb(1'b1, 32'h0, 32'h0);
		uwf_user_model_i.burst(1'b1, 1011);
		#1 chk(request_queue_full, 1'b0);
		uwf_user_model_i.burst(1'b1, 1);
		#1 chk(request_queue_full, 1'b1);
		uwf_user_model_i.burst(1'b1, 12);
		uwf_user_model_i.burst(1'b0, 499);
		#1 chk(write_queue_full, 1'b0);
		uwf_user_model_i.burst(1'b0, 1);
		#1 chk(write_queue_full, 1'b1);
		uwf_user_model_i.burst(1'b0, 12);
		ahb(1'b0, 32'h8, 32'h0);
		chk(rd, 32'h0200_0400);
		ahb(1'b0, 32'h4, 32'h0);
		chk(rd, 32'h0000_0015);
		$display("test fill done");
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_write();
		t_read();
		t_fill();
		summarize();
	end
endmodule // uwf_tb_top
`default_nettype wire
